// [cpml_pkg.sv]
// Shared constants, register map and carrier types of the port mode logic.
package cpml_pkg;
    localparam int NUM_PORTS = 7;
    localparam int PORT_W = 8;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    localparam int HOST_AW = 16;
    localparam int HOST_DW = 16;
    localparam int NIBBLE_W = 4;

    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;

    // Ports that own a control register, an open-drain select, an
    // array output-enable OR term, and address inputs.
    localparam logic [6:0] CTRL_PORTS = 7'h70;
    localparam logic [6:0] DRIVE_PORTS = 7'h5B;
    localparam logic [6:0] OE_TERM_PORTS = 7'h27;
    localparam logic [6:0] ADDR_IN_PORTS = 7'h2F;
    localparam logic [6:0] ADDR_OUT_PORTS = 7'h70;

    typedef logic [NUM_PORTS-1:0][PORT_W-1:0] cpml_pins_t;

    // Port D has only four pins.
    localparam cpml_pins_t PIN_MASK = 56'hFF_FF_FF_0F_FF_FF_FF;
    localparam logic [PORT_W-1:0] REG_RESET = 8'h00;

    // Register map: one block of 0x20 bytes per port, index in paddr[7:5].
    localparam int PORT_SEL_LSB = 5;
    localparam int PORT_SEL_W = 3;
    localparam logic [4:0] OFS_DATA_IN = 5'h00;
    localparam logic [4:0] OFS_DATA_OUT = 5'h04;
    localparam logic [4:0] OFS_DIR = 5'h08;
    localparam logic [4:0] OFS_CTRL = 5'h0C;
    localparam logic [4:0] OFS_DRIVE = 5'h10;
    localparam logic [APB_AW-1:0] ADDR_PORT_TOP = 12'h0E0;
    localparam logic [APB_AW-1:0] ADDR_MAP_REG = 12'h100;
    localparam int MAP_PERIPH_BIT = 7;

    typedef struct packed {
        logic [APB_AW-1:0] paddr;
        logic pwrite;
        logic [APB_DW-1:0] pwdata;
        logic psel;
        logic penable;
    } cpml_apb_req_t;

    typedef struct packed {
        logic [APB_DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } cpml_apb_rsp_t;

    typedef struct packed {
        cpml_pins_t dataOut;
        cpml_pins_t dir;
        cpml_pins_t ctrl;
        cpml_pins_t drive;
        logic [PORT_W-1:0] mapReg;
    } cpml_regs_t;

    // Settings fixed when the device is configured.
    typedef struct packed {
        cpml_pins_t pldOutSel;
        cpml_pins_t pldInSel;
        cpml_pins_t addrInSel;
        cpml_pins_t decodeRef;
        logic dataPortMode;
        logic lowAddrNotMuxed;
        logic host8bit;
    } cpml_cfg_t;

    typedef struct packed {
        logic [HOST_AW-1:0] latchedAddr;
        logic [HOST_DW-1:0] readData;
        logic hostRead;
        logic hostWrite;
        logic periphSelA;
        logic periphSelB;
        logic addrStrobe;
    } cpml_host_t;
endpackage : cpml_pkg

// [cpml_addr_capture.sv]
// Input macrocell capture of address input pins on the address latch strobe.
`timescale 1ns/1ps
`default_nettype none
module cpml_addr_capture (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Pin levels and selection.
    input wire cpml_pkg::cpml_pins_t pinIn,
    input wire cpml_pkg::cpml_pins_t addrPins,
    input wire logic strobe,
    // Results toward the logic arrays.
    output cpml_pkg::cpml_pins_t arrayIn,
    output cpml_pkg::cpml_pins_t capturedAddr
);
    import cpml_pkg::*;

    typedef struct packed {
        cpml_pins_t arrayIn;
        cpml_pins_t captured;
    } cpml_cap_state_t;

    cpml_cap_state_t state_reg;
    cpml_cap_state_t state_next;

    always_comb begin
        state_next = state_reg;
        state_next.arrayIn = pinIn & PIN_MASK;
        if (strobe) begin
            state_next.captured = (state_reg.captured & ~addrPins)
                | (pinIn & addrPins);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign arrayIn = state_reg.arrayIn;
    assign capturedAddr = state_reg.captured;
endmodule : cpml_addr_capture
`default_nettype wire

// [cpml_apb_regs.sv]
// APB slave holding the port configuration and output data registers.
`timescale 1ns/1ps
`default_nettype none
module cpml_apb_regs (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB.
    input wire cpml_pkg::cpml_apb_req_t apbReq,
    output cpml_pkg::cpml_apb_rsp_t apbRsp,
    // Live pin levels and stored registers.
    input wire cpml_pkg::cpml_pins_t pinIn,
    output cpml_pkg::cpml_regs_t regs
);
    import cpml_pkg::*;

    typedef struct packed {
        cpml_regs_t regs;
        cpml_apb_rsp_t rsp;
    } cpml_reg_state_t;

    cpml_reg_state_t state_reg;
    cpml_reg_state_t state_next;

    logic [PORT_SEL_W-1:0] portSel;
    logic [4:0] subSel;
    logic inPortSpace;
    logic [PORT_W-1:0] wByte;

    always_comb begin
        state_next = state_reg;
        portSel = apbReq.paddr[PORT_SEL_LSB +: PORT_SEL_W];
        subSel = apbReq.paddr[PORT_SEL_LSB-1:0];
        inPortSpace = apbReq.paddr < ADDR_PORT_TOP;
        wByte = apbReq.pwdata[PORT_W-1:0];
        state_next.rsp.pready = 1'b0;
        state_next.rsp.pslverr = 1'b0;
        // First access cycle prepares the answer, the next one completes it.
        if (apbReq.psel && apbReq.penable && !state_reg.rsp.pready) begin
            state_next.rsp.pready = 1'b1;
            state_next.rsp.prdata = '0;
            if (apbReq.paddr == ADDR_MAP_REG) begin
                state_next.rsp.prdata[PORT_W-1:0] = state_reg.regs.mapReg;
            end else if (inPortSpace) begin
                unique case (subSel)
                    OFS_DATA_IN: begin
                        state_next.rsp.prdata[PORT_W-1:0] =
                            pinIn[portSel] & PIN_MASK[portSel]; // [RQ3]
                    end
                    OFS_DATA_OUT: begin
                        state_next.rsp.prdata[PORT_W-1:0] =
                            state_reg.regs.dataOut[portSel]; // [RQ22]
                    end
                    OFS_DIR: begin
                        state_next.rsp.prdata[PORT_W-1:0] =
                            state_reg.regs.dir[portSel];
                    end
                    OFS_CTRL: begin
                        state_next.rsp.prdata[PORT_W-1:0] =
                            state_reg.regs.ctrl[portSel];
                    end
                    OFS_DRIVE: begin
                        state_next.rsp.prdata[PORT_W-1:0] =
                            state_reg.regs.drive[portSel];
                    end
                    default: begin
                        state_next.rsp.pslverr = 1'b1;
                    end
                endcase
            end else begin
                state_next.rsp.pslverr = 1'b1;
            end
        end
        // Writes land on the edge that samples pready high.
        if (apbReq.psel && apbReq.penable && state_reg.rsp.pready
            && apbReq.pwrite && !state_reg.rsp.pslverr) begin
            if (apbReq.paddr == ADDR_MAP_REG) begin
                state_next.regs.mapReg = wByte;
            end else if (inPortSpace) begin
                unique case (subSel)
                    OFS_DATA_OUT: begin
                        state_next.regs.dataOut[portSel] =
                            wByte & PIN_MASK[portSel]; // [RQ22]
                    end
                    OFS_DIR: begin
                        state_next.regs.dir[portSel] =
                            wByte & PIN_MASK[portSel]; // [RQ5]
                    end
                    OFS_CTRL: begin
                        if (CTRL_PORTS[portSel]) begin
                            state_next.regs.ctrl[portSel] = wByte; // [RQ4]
                        end
                    end
                    OFS_DRIVE: begin
                        if (DRIVE_PORTS[portSel]) begin
                            state_next.regs.drive[portSel] =
                                wByte & PIN_MASK[portSel];
                        end
                    end
                    default: begin
                        state_next.regs = state_reg.regs;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0; // [RQ20]
        end else begin
            state_reg <= state_next;
        end
    end

    assign apbRsp = state_reg.rsp;
    assign regs = state_reg.regs;
endmodule : cpml_apb_regs
`default_nettype wire

// [cpml_top.sv]
// Pin mode steering for the seven configurable I/O ports.
//
// Notes on behaviour
// [RQ1] Ports E, F, G: control bit 0 makes the pin host-controlled I/O.
// [RQ2] Host I/O output pins drive the stored output data bit.
// [RQ3] Host I/O input pins: a port read returns the live pin level.
// [RQ4] Ports A, B, C: no control register; host I/O unless logic-assigned.
// [RQ5] Direction follows the direction bit or the array output-enable term.
// [RQ6] Ports A, B, C, F: output enable is direction OR array enable term.
// [RQ7] Logic pin drives macrocell output; off when enable and direction low.
// [RQ8] Host never sets direction on a pin used as logic input.
// [RQ9] Address out drives on enable term or on direction and control both 1.
// [RQ10] Host sets address-out direction and control bits at run time.
// [RQ11] E, F carry a3-a0 and a7-a4; G carries a11-a8 and a15-a12.
// [RQ12] Unmultiplexed low address: E, F low nibbles off; 8-bit host G a7-a0.
// [RQ13] Upper address pins feed arrays, captured on the address strobe.
// [RQ14] Pins used by the chip-select decode count as address inputs.
// [RQ15] Separate-bus host: F and G become data bus, general I/O off.
// [RQ16] Mapping register bit 7 makes port F a peripheral data buffer.
// [RQ17] Peripheral buffer off without a select; direction follows access.
// [RQ18] Test port takes port E pins only while programming is active.
// [RQ19] Host must not boot external memory over address-out pins.
// [RQ20] Control, direction, drive registers reset to zero; pins are inputs.
// [RQ21] Control 1 selects address out, 0 selects host I/O.
// [RQ22] Writes land on the completing edge; reads return register contents.
`timescale 1ns/1ps
`default_nettype none
module cpml_top #(
    parameter int ADDR_BITS = cpml_pkg::HOST_AW
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB register port.
    input wire cpml_pkg::cpml_apb_req_t apbReq,
    output cpml_pkg::cpml_apb_rsp_t apbRsp,
    // Configuration and host bus.
    input wire cpml_pkg::cpml_cfg_t cfg,
    input wire cpml_pkg::cpml_host_t host,
    // Logic array terms.
    input wire cpml_pkg::cpml_pins_t macrocellOut,
    input wire cpml_pkg::cpml_pins_t oeTerm,
    // Test port sharing of port E.
    input wire logic testPortActive,
    input wire logic [cpml_pkg::PORT_W-1:0] testOut,
    input wire logic [cpml_pkg::PORT_W-1:0] testOeN,
    // Port pins.
    input wire cpml_pkg::cpml_pins_t pinIn,
    output cpml_pkg::cpml_pins_t pinOut,
    output cpml_pkg::cpml_pins_t pinOeN,
    output cpml_pkg::cpml_pins_t pinOpenDrain,
    // Results toward the host and the arrays.
    output logic [cpml_pkg::HOST_DW-1:0] dataBusIn,
    output logic [cpml_pkg::PORT_W-1:0] periphRdata,
    output cpml_pkg::cpml_pins_t arrayIn,
    output cpml_pkg::cpml_pins_t capturedAddr
);
    import cpml_pkg::*;

    if (ADDR_BITS != HOST_AW) begin : gBadAddr
        $error("cpml_top serves a 16-bit latched host address only.");
    end

    typedef struct packed {
        cpml_pins_t pinOut;
        cpml_pins_t pinOeN;
        logic [HOST_DW-1:0] dataBusIn;
        logic [PORT_W-1:0] periphRdata;
    } cpml_top_state_t;

    cpml_top_state_t state_reg;
    cpml_top_state_t state_next;
    cpml_regs_t regs;
    cpml_pins_t addrPins;
    logic periphEn;
    logic periphSel;

    assign addrPins = (cfg.addrInSel | cfg.decodeRef) & PIN_MASK; // [RQ14]

    cpml_apb_regs uRegs (
        .clk(clk),
        .rst(rst),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .pinIn(pinIn),
        .regs(regs)
    );

    cpml_addr_capture uCapture (
        .clk(clk),
        .rst(rst),
        .pinIn(pinIn),
        .addrPins(addrPins),
        .strobe(host.addrStrobe), // [RQ13]
        .arrayIn(arrayIn),
        .capturedAddr(capturedAddr)
    );

    // Gives the latched address bit that a pin carries in address-out mode.
    function automatic logic addrLane(input int p, input int b,
                                      input logic [HOST_AW-1:0] a,
                                      input logic narrow);
        logic bitVal;
        bitVal = a[b]; // [RQ11]
        if (p == PORT_G && !narrow) begin
            bitVal = a[PORT_W + b]; // [RQ11]
        end
        return bitVal; // [RQ12]
    endfunction : addrLane

    always_comb begin
        state_next = state_reg;
        periphEn = regs.mapReg[MAP_PERIPH_BIT]; // [RQ16]
        periphSel = host.periphSelA || host.periphSelB;
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
                logic drv;
                logic val;
                logic oeOr;
                logic addrOk;
                drv = 1'b0;
                val = 1'b0;
                oeOr = OE_TERM_PORTS[p] && oeTerm[p][b];
                addrOk = ADDR_OUT_PORTS[p] && regs.ctrl[p][b]
                    && !(p != PORT_G && b < NIBBLE_W
                         && cfg.lowAddrNotMuxed); // [RQ12]
                if (!PIN_MASK[p][b]) begin
                    drv = 1'b0;
                end else if (p == PORT_E && testPortActive) begin
                    drv = !testOeN[b]; // [RQ18]
                    val = testOut[b];
                end else if ((p == PORT_F || p == PORT_G)
                             && cfg.dataPortMode) begin
                    drv = host.hostRead; // [RQ15]
                    val = host.readData[(p - PORT_F) * PORT_W + b];
                end else if (p == PORT_F && periphEn) begin
                    drv = periphSel && host.hostWrite; // [RQ17]
                    val = host.readData[b];
                end else if (ADDR_IN_PORTS[p] && addrPins[p][b]) begin
                    drv = 1'b0; // [RQ13]
                end else if (cfg.pldOutSel[p][b] || cfg.pldInSel[p][b]) begin
                    drv = cfg.pldOutSel[p][b]
                        && (oeTerm[p][b] || regs.dir[p][b]); // [RQ7] [RQ8]
                    val = macrocellOut[p][b];
                end else if (addrOk) begin
                    drv = oeTerm[p][b] || regs.dir[p][b]; // [RQ9] [RQ21]
                    val = addrLane(p, b, host.latchedAddr, cfg.host8bit);
                end else begin
                    drv = regs.dir[p][b] || oeOr; // [RQ1] [RQ5] [RQ6]
                    val = regs.dataOut[p][b]; // [RQ2]
                end
                state_next.pinOut[p][b] = val;
                state_next.pinOeN[p][b] = !drv;
            end
        end
        if (cfg.dataPortMode && host.hostWrite) begin
            state_next.dataBusIn = {pinIn[PORT_G], pinIn[PORT_F]};
        end
        if (periphEn && periphSel && host.hostRead) begin
            state_next.periphRdata = pinIn[PORT_F]; // [RQ17]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.pinOeN <= '1; // [RQ20]
        end else begin
            state_reg <= state_next;
        end
    end

    assign pinOut = state_reg.pinOut;
    assign pinOeN = state_reg.pinOeN;
    assign pinOpenDrain = regs.drive;
    assign dataBusIn = state_reg.dataBusIn;
    assign periphRdata = state_reg.periphRdata;

    // Checks on the steering, each against its cause.
    default clocking cpmlClk @(posedge clk);
    endclocking
    default disable iff (rst);

    logic plainA0;
    logic plainF3;
    logic pldA1;
    logic addrG4;
    logic lowE0;
    assign plainA0 = !cfg.pldOutSel[PORT_A][0] && !cfg.pldInSel[PORT_A][0]
        && !addrPins[PORT_A][0];
    assign plainF3 = !cfg.dataPortMode && !periphEn && !regs.ctrl[PORT_F][3]
        && !cfg.pldOutSel[PORT_F][3] && !cfg.pldInSel[PORT_F][3]
        && !addrPins[PORT_F][3];
    assign pldA1 = cfg.pldOutSel[PORT_A][1] && !addrPins[PORT_A][1];
    assign addrG4 = !cfg.dataPortMode && regs.ctrl[PORT_G][4]
        && regs.dir[PORT_G][4] && !cfg.host8bit
        && !cfg.pldOutSel[PORT_G][4] && !cfg.pldInSel[PORT_G][4];
    assign lowE0 = !testPortActive && cfg.lowAddrNotMuxed
        && regs.ctrl[PORT_E][0] && regs.dir[PORT_E][0]
        && !cfg.pldOutSel[PORT_E][0] && !cfg.pldInSel[PORT_E][0];

    sequence readDataInB;
        apbReq.psel && apbReq.penable && !apbRsp.pready && !apbReq.pwrite
            && apbReq.paddr == {4'h0, 3'(PORT_B), OFS_DATA_IN};
    endsequence
    sequence writeDirC;
        apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
            && apbReq.paddr == {4'h0, 3'(PORT_C), OFS_DIR};
    endsequence

    mcu_out_a: assert property (plainA0 && regs.dir[PORT_A][0] |=> // [RQ2]
        !pinOeN[PORT_A][0] && pinOut[PORT_A][0] == $past(regs.dataOut[0][0]))
        else $error("Host output pin does not follow data out.");
    data_in_a: assert property (readDataInB ##1 apbRsp.pready // [RQ3]
        |-> apbRsp.prdata[PORT_W-1:0] == $past(pinIn[PORT_B]))
        else $error("Port read does not return the live pin level.");
    oe_or_a: assert property (plainF3 && oeTerm[PORT_F][3] // [RQ6]
        && !regs.dir[PORT_F][3] |=> !pinOeN[PORT_F][3])
        else $error("Array enable term fails to drive port F.");
    pld_tri_a: assert property (pldA1 && !oeTerm[PORT_A][1] // [RQ7]
        && !regs.dir[PORT_A][1] |=> pinOeN[PORT_A][1])
        else $error("Logic output not tri-stated.");
    addr_out_a: assert property (addrG4 |=> !pinOeN[PORT_G][4] // [RQ11]
        && pinOut[PORT_G][4] == $past(host.latchedAddr[12]))
        else $error("Port G high nibble does not carry a12.");
    low_nib_a: assert property (lowE0 |=> // [RQ12]
        pinOut[PORT_E][0] == $past(regs.dataOut[PORT_E][0]))
        else $error("Port E low nibble carries address.");
    data_port_a: assert property (cfg.dataPortMode && !host.hostRead // [RQ15]
        |=> pinOeN[PORT_F] == '1 && pinOeN[PORT_G] == '1)
        else $error("Data port drives outside a host read.");
    periph_off_a: assert property (!cfg.dataPortMode && periphEn // [RQ17]
        && !periphSel |=> pinOeN[PORT_F] == '1)
        else $error("Peripheral buffer drives without a select.");
    test_port_a: assert property (testPortActive |=> // [RQ18]
        pinOeN[PORT_E] == $past(testOeN) && pinOut[PORT_E] == $past(testOut))
        else $error("Test port does not own port E.");
    dir_write_a: assert property (writeDirC |=> // [RQ22]
        regs.dir[PORT_C] == $past(apbReq.pwdata[PORT_W-1:0]))
        else $error("Direction write lost.");
    reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) // [RQ20]
        rst |=> regs.dir == '0 && regs.ctrl == '0 && regs.drive == '0
        && pinOeN == '1)
        else $error("Configuration not cleared by reset.");
endmodule : cpml_top
`default_nettype wire

// [cpml_host_model.sv]
// Host bus model that presents address, data, access and select strobes.
`timescale 1ns/1ps
`default_nettype none
module cpml_host_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Commands from the bench.
    input wire logic [15:0] addr,
    input wire logic [15:0] data,
    input wire logic rd,
    input wire logic wr,
    input wire logic selA,
    input wire logic selB,
    input wire logic stb,
    // Bus toward the device.
    output cpml_pkg::cpml_host_t host
);
    import cpml_pkg::*;
    logic [15:0] lastData;
    // Outside an access the data lines show the inverse of the last value,
    // so a stale value can never pass for a driven one.
    always @(posedge clk) begin
        if (rst) begin
            host <= '0;
            lastData <= '0;
        end else begin
            host.latchedAddr <= addr;
            host.readData <= (rd | wr) ? data : ~lastData;
            lastData <= (rd | wr) ? data : lastData;
            host.hostRead <= rd;
            host.hostWrite <= wr;
            host.periphSelA <= selA;
            host.periphSelB <= selB;
            host.addrStrobe <= stb;
        end
    end
endmodule : cpml_host_model
`default_nettype wire

// [configurable_port_mode_logic_tb.sv]
// Self-checking bench for the port mode logic.
`timescale 1ns/1ps
`default_nettype none
module configurable_port_mode_logic_tb;
    import cpml_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cpml_apb_req_t apbReq = '0;
    cpml_apb_rsp_t apbRsp;
    cpml_cfg_t cfg = '0;
    cpml_pins_t mc = '0, oe = '0, ext = '0;
    cpml_pins_t pinIn, pinOut, pinOeN, capAddr, od, arr;
    cpml_host_t host;
    logic tpa = 1'b0;
    logic [7:0] tOut = '0, tOeN = '0, pRd, v;
    logic [15:0] hAddr = '0, hData = '0, dBus, a;
    logic hRd = 1'b0, hWr = 1'b0, sA = 1'b0, sB = 1'b0, stb = 1'b0;
    int num_errors = 0, samples_checked = 0, seed = 32'h3199;
    logic [33:0] expQ[$];
    logic [33:0] expNote;

    always #5 clk = ~clk;
    assign pinIn = (~pinOeN & pinOut) | (pinOeN & ext);

    cpml_top #(.ADDR_BITS(HOST_AW)) i_cpml_top (.clk(clk), .rst(rst),
        .apbReq(apbReq), .apbRsp(apbRsp), .cfg(cfg), .host(host),
        .macrocellOut(mc), .oeTerm(oe), .testPortActive(tpa),
        .testOut(tOut), .testOeN(tOeN), .pinIn(pinIn), .pinOut(pinOut),
        .pinOeN(pinOeN), .pinOpenDrain(od), .dataBusIn(dBus),
        .periphRdata(pRd), .arrayIn(arr), .capturedAddr(capAddr));
    cpml_host_model i_cpml_host_model (.clk(clk), .rst(rst), .addr(hAddr),
        .data(hData), .rd(hRd), .wr(hWr), .selA(sA), .selB(sB),
        .stb(stb), .host(host));

    task automatic end_of_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [63:0] seen, exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [11:0] ra(int p, logic [4:0] o);
        return 12'(p * 32) | 12'(o);
    endfunction : ra

    // The note holds {compare data, error expected, read data}.
    task automatic apb(input logic [11:0] ad, input logic w,
                       input logic [31:0] wd, input logic [33:0] ex);
        int n;
        expQ.push_back(ex);
        @(posedge clk);
        apbReq <= '{paddr: ad, pwrite: w, pwdata: wd, psel: 1'b1,
                    penable: 1'b0};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (apbRsp.pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            end_of_test();
        end
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask : apb

    task automatic regWrite(input logic [11:0] ad, input logic [7:0] d);
        apb(ad, 1'b1, {24'h0, d}, 34'h0);
    endtask : regWrite

    task automatic regRead(input logic [11:0] ad, input logic [31:0] x,
                           input logic er);
        apb(ad, 1'b0, 32'h0, {1'b1, er, x});
    endtask : regRead

    task automatic pins(int p, logic [7:0] oeN, logic [7:0] out);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(pinOeN[p], oeN, "pinOeN");
        check(pinOut[p] & ~oeN, out & ~oeN, "pinOut");
    endtask : pins

    always @(posedge clk) begin
        if (!rst && apbReq.psel && apbReq.penable
            && apbRsp.pready === 1'b1) begin
            expNote = expQ.pop_front();
            check(apbRsp.pslverr, expNote[32], "pslverr");
            if (expNote[33]) begin
                check(apbRsp.prdata, expNote[31:0], "prdata");
            end
        end
    end

    initial begin
        ext = 56'({$random(seed), $random(seed)});
        mc = 56'({$random(seed), $random(seed)});
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(pinOeN, {56{1'b1}}, "pinOeN");
        for (int p = 0; p < NUM_PORTS; p++) begin
            regRead(ra(p, OFS_DIR), 32'h0, 1'b0);
            regRead(ra(p, OFS_CTRL), 32'h0, 1'b0);
            regRead(ra(p, OFS_DRIVE), 32'h0, 1'b0);
        end
        v = 8'($random(seed));
        regWrite(ra(PORT_A, OFS_DATA_OUT), v);
        regWrite(ra(PORT_A, OFS_DIR), 8'h0D);
        regRead(ra(PORT_A, OFS_DATA_OUT), {24'h0, v}, 1'b0);
        pins(PORT_A, 8'hF2, v);
        @(posedge clk);
        oe[PORT_A] <= 8'h30;
        oe[PORT_C] <= 8'h0F;
        oe[PORT_F] <= 8'h08;
        cfg.pldInSel[PORT_B] <= 8'hFF; // Port B direction stays cleared.
        pins(PORT_A, 8'hC2, v);
        pins(PORT_C, 8'hF0, 8'h00);
        pins(PORT_F, 8'hF7, 8'h00);
        @(posedge clk);
        cfg.pldOutSel[PORT_C] <= 8'hFF;
        cfg.pldOutSel[PORT_A] <= 8'h02;
        oe[PORT_C] <= 8'h00;
        pins(PORT_C, 8'hFF, 8'h00);
        pins(PORT_A, 8'hC2, v);
        @(posedge clk);
        oe[PORT_C] <= 8'h0F;
        oe[PORT_A] <= 8'h32;
        pins(PORT_C, 8'hF0, mc[PORT_C]);
        pins(PORT_A, 8'hC0, {v[7:2], mc[PORT_A][1], v[0]});
        regWrite(ra(PORT_C, OFS_DIR), 8'h10);
        pins(PORT_C, 8'hE0, mc[PORT_C]);
        regWrite(ra(PORT_D, OFS_DIR), 8'hF0);
        regRead(ra(PORT_D, OFS_DIR), 32'h0, 1'b0);
        regRead(ra(PORT_D, OFS_DATA_IN), {28'h0, ext[PORT_D][3:0]},
            1'b0);
        regRead(ra(PORT_B, OFS_DATA_IN), {24'h0, ext[PORT_B]}, 1'b0);
        regWrite(ra(PORT_B, OFS_DRIVE), 8'hA5);
        @(negedge clk);
        check(od[PORT_B], 8'hA5, "pinOpenDrain");
        check(arr[PORT_D], {4'h0, ext[PORT_D][3:0]}, "arrayIn");
        apb(12'h0E0, 1'b1, 32'hFF, {2'b01, 32'h0});
        regRead(ra(PORT_A, 5'h14), 32'h0, 1'b1);
        regWrite(ra(PORT_A, OFS_CTRL), 8'hFF);
        regRead(ra(PORT_A, OFS_CTRL), 32'h0, 1'b0);
        a = 16'($random(seed));
        hAddr <= a;
        regWrite(ra(PORT_G, OFS_DATA_OUT), v);
        for (int p = PORT_E; p <= PORT_G; p += 2) begin
            regWrite(ra(p, OFS_CTRL), 8'hFF);
            regWrite(ra(p, OFS_DIR), 8'hFF);
        end
        pins(PORT_E, 8'h00, a[7:0]);
        pins(PORT_G, 8'h00, a[15:8]);
        @(posedge clk);
        cfg.host8bit <= 1'b1;
        cfg.lowAddrNotMuxed <= 1'b1;
        pins(PORT_G, 8'h00, a[7:0]);
        pins(PORT_E, 8'h00, {a[7:4], 4'h0});
        regWrite(ra(PORT_G, OFS_CTRL), 8'h00);
        pins(PORT_G, 8'h00, v);
        v = 8'($random(seed));
        @(posedge clk);
        tpa <= 1'b1;
        tOut <= v;
        tOeN <= 8'h5A;
        pins(PORT_E, 8'h5A, v);
        @(posedge clk);
        tpa <= 1'b0;
        pins(PORT_E, 8'h00, {a[7:4], 4'h0});
        regWrite(ADDR_MAP_REG, 8'h80);
        regRead(ADDR_MAP_REG, 32'h80, 1'b0);
        pins(PORT_F, 8'hFF, 8'h00);
        a = 16'($random(seed));
        @(posedge clk);
        hData <= a;
        hWr <= 1'b1;
        sA <= 1'b1;
        pins(PORT_F, 8'h00, a[7:0]);
        @(posedge clk);
        hWr <= 1'b0;
        sA <= 1'b0;
        hRd <= 1'b1;
        sB <= 1'b1;
        pins(PORT_F, 8'hFF, 8'h00);
        check(pRd, ext[PORT_F], "periphRdata");
        @(posedge clk);
        cfg.dataPortMode <= 1'b1;
        pins(PORT_G, 8'h00, a[15:8]);
        @(posedge clk);
        hRd <= 1'b0;
        hWr <= 1'b1;
        pins(PORT_F, 8'hFF, 8'h00);
        check(dBus, {ext[PORT_G], ext[PORT_F]}, "dataBusIn");
        @(posedge clk);
        cfg.addrInSel[PORT_A] <= 8'hFF;
        cfg.decodeRef[PORT_C] <= 8'hFF;
        stb <= 1'b1;
        pins(PORT_A, 8'hFF, 8'h00);
        pins(PORT_C, 8'hFF, 8'h00);
        check(capAddr[PORT_A], ext[PORT_A], "capturedAddr");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        regRead(ra(PORT_A, OFS_DIR), 32'h0, 1'b0);
        end_of_test();
    end
endmodule : configurable_port_mode_logic_tb
`default_nettype wire
